// ### dram_cmd_pkg.sv
package dram_cmd_pkg;

  localparam int BANK_BITS = 3;
  localparam int BANKS = 8;
  localparam int ROW_BITS = 14;
  localparam int COL_BITS = 10;
  localparam int COL_SENT_BITS = 8;
  localparam int FETCH_BITS = 256;
  localparam int BEATS = 8;
  localparam int BEAT_BITS = 32;
  localparam int BEAT_IDX_BITS = 3;
  localparam int FETCH_IDX_BITS = 6;
  localparam int MODE_BITS = 8;
  localparam int MODE_TRAIN_BIT = 0;
  localparam int MODE_ORDER_BIT = 1;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [2:0] LAST_BEAT = 3'h7;

  typedef enum logic [3:0] {
    op_nop, op_act, op_rd, op_wr, op_pre, op_mrw, op_mrr,
    op_mpc, op_sre, op_srx, op_pde, op_pdx
  } op_type;

  typedef enum logic [3:0] {
    st_idle, st_active, st_read, st_write, st_mrr, st_mrw,
    st_self_ref, st_power_down, st_training
  } state_type;

  // Column carries C9..C2; the two lowest column bits are implied zero.
  typedef struct packed {
    logic valid;
    op_type op;
    logic [BANK_BITS-1:0] bank;
    logic [ROW_BITS-1:0] row;
    logic [COL_SENT_BITS-1:0] col;
    logic [MODE_BITS-1:0] mode;
  } cmd_type;

  typedef struct packed {
    logic write;
    logic [BANK_BITS-1:0] bank;
    logic [ROW_BITS-1:0] row;
    logic [FETCH_IDX_BITS-1:0] fetch;
    logic [FETCH_BITS-1:0] data;
  } req_type;

endpackage

// ### dram_bank_command_state_machine.sv
`timescale 1ns/100ps
// Operation
// - An access begins with an Activate that opens the bank, and only then may Read or Write reach that bank.
// - The bank and row bits taken with Activate select which bank opens and which row it holds.
// - The bits taken with Read or Write select the bank and the first column of the burst.
// - A channel has eight banks on three bank bits, fourteen row bits and ten column bits.
// - The two lowest column bits are taken as zero and are not carried on the command bus.
// - One wide core transfer of 256 bits per access is split into eight serial beats at the data port.
// - Reads and writes are bursts from the chosen column through a fixed length of eight beats in a programmed order.
// - In self refresh the device accepts power-down, mode register read, mode register write and multi-purpose entries.
// - Idle means every bank of the channel is precharged.
// - A mode register write that enters training stays in training until told to leave.
// - A multi-purpose command that enters training does not return to idle by itself.
// - An automatically returning state goes back to the state it was entered from.
// - The active-low reset forces the device into its reset state from any state.
// - A low on the single reset input resets every channel of the die.
module dram_bank_command_state_machine #(
  parameter int ROW_KEEP = 2
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic link_clk_in,
  input wire logic reset_n_in,
  input wire dram_cmd_pkg::cmd_type cmd_in,
  input wire logic wr_valid_in,
  input wire logic [dram_cmd_pkg::BEAT_BITS-1:0] wr_data_in,
  output logic link_ready_out,
  output logic rd_valid_out,
  output logic [dram_cmd_pkg::BEAT_BITS-1:0] rd_data_out,
  output logic cmd_error_out,
  output logic [dram_cmd_pkg::BANKS-1:0] bank_open_out,
  output logic self_refresh_out,
  output logic training_out,
  output logic [15:0] access_count_out
);

  localparam int AW = dram_cmd_pkg::BANK_BITS + ROW_KEEP + dram_cmd_pkg::FETCH_IDX_BITS;
  localparam int BB = dram_cmd_pkg::BEAT_BITS;

  // Link reset: raised at once by either reset, released on the link clock.
  wire link_arst = reset_in | ~reset_n_in;
  logic [1:0] link_rst_pipe;
  wire link_rst = link_rst_pipe[1];

  always_ff @(posedge link_clk_in or posedge link_arst)
  begin
    if (link_arst)
      link_rst_pipe <= 2'b11;
    else
      link_rst_pipe <= {link_rst_pipe[0], 1'b0};
  end

  dram_cmd_pkg::state_type state;
  dram_cmd_pkg::state_type ret_state;
  dram_cmd_pkg::state_type next_state;
  dram_cmd_pkg::state_type next_ret;
  logic [dram_cmd_pkg::MODE_BITS-1:0] mode;
  logic [dram_cmd_pkg::BANKS-1:0] bank_open;
  logic [dram_cmd_pkg::ROW_BITS-1:0] open_row [dram_cmd_pkg::BANKS];
  logic [dram_cmd_pkg::FETCH_BITS-1:0] buffer;
  logic [dram_cmd_pkg::FETCH_BITS-1:0] merged;
  logic [2:0] beat_cnt;
  logic [2:0] start_beat;
  logic pending;
  logic streaming;
  logic req_tgl;
  dram_cmd_pkg::req_type req;
  logic [1:0] ack_sync;
  logic ack_seen;
  logic ack_tgl;
  logic [dram_cmd_pkg::FETCH_BITS-1:0] rsp;
  logic bad;

  wire dram_cmd_pkg::op_type op = cmd_in.op;
  wire can_take = state != dram_cmd_pkg::st_read && state != dram_cmd_pkg::st_write &&
                  state != dram_cmd_pkg::st_mrr && state != dram_cmd_pkg::st_mrw;
  wire take = cmd_in.valid && can_take;
  wire bank_hit = bank_open[cmd_in.bank];
  wire [dram_cmd_pkg::BANKS-1:0] bank_mask = dram_cmd_pkg::BANKS'(1) << cmd_in.bank;
  wire last_close = (bank_open & ~bank_mask) == '0;
  wire train_req = cmd_in.mode[dram_cmd_pkg::MODE_TRAIN_BIT];
  wire order_ilv = mode[dram_cmd_pkg::MODE_ORDER_BIT];
  wire ack_edge = ack_sync[1] ^ ack_seen;
  wire read_done = streaming && beat_cnt == dram_cmd_pkg::LAST_BEAT;
  wire write_done = pending && ack_edge;
  // Burst order is sequential with wrap, or interleaved, as the mode selects.
  wire [2:0] beat_idx = order_ilv ? (start_beat ^ beat_cnt) : 3'(start_beat + beat_cnt);
  wire [dram_cmd_pkg::FETCH_IDX_BITS-1:0] fetch_idx = cmd_in.col[7:2];
  wire [2:0] col_beat = {cmd_in.col[1:0], 1'b0};
  wire act_go = take && op == dram_cmd_pkg::op_act && next_state == dram_cmd_pkg::st_active && !bad;
  wire rd_go = take && op == dram_cmd_pkg::op_rd && next_state == dram_cmd_pkg::st_read;
  wire wr_go = take && op == dram_cmd_pkg::op_wr && next_state == dram_cmd_pkg::st_write;
  wire pre_go = take && op == dram_cmd_pkg::op_pre && !bad;
  wire mrw_go = take && op == dram_cmd_pkg::op_mrw && !bad;
  wire mrr_go = take && op == dram_cmd_pkg::op_mrr && !bad;

  always_comb
  begin
    next_state = state;
    next_ret = ret_state;
    bad = 1'b0;
    case (state)
      dram_cmd_pkg::st_idle:
      begin
        if (take)
        begin
          case (op)
            dram_cmd_pkg::op_nop: ;
            dram_cmd_pkg::op_act: next_state = dram_cmd_pkg::st_active;
            dram_cmd_pkg::op_mrw:
            begin
              next_ret = dram_cmd_pkg::st_idle;
              next_state = train_req ? dram_cmd_pkg::st_training : dram_cmd_pkg::st_mrw;
            end
            dram_cmd_pkg::op_mrr:
            begin
              next_ret = dram_cmd_pkg::st_idle;
              next_state = dram_cmd_pkg::st_mrr;
            end
            dram_cmd_pkg::op_mpc: if (train_req) next_state = dram_cmd_pkg::st_training;
            dram_cmd_pkg::op_sre: next_state = dram_cmd_pkg::st_self_ref;
            dram_cmd_pkg::op_pde:
            begin
              next_ret = dram_cmd_pkg::st_idle;
              next_state = dram_cmd_pkg::st_power_down;
            end
            default: bad = 1'b1;
          endcase
        end
      end
      dram_cmd_pkg::st_active:
      begin
        if (take)
        begin
          case (op)
            dram_cmd_pkg::op_nop: ;
            dram_cmd_pkg::op_act: bad = bank_hit;
            dram_cmd_pkg::op_rd:
            begin
              bad = !bank_hit;
              if (bank_hit) next_state = dram_cmd_pkg::st_read;
            end
            dram_cmd_pkg::op_wr:
            begin
              bad = !bank_hit;
              if (bank_hit) next_state = dram_cmd_pkg::st_write;
            end
            dram_cmd_pkg::op_pre: if (last_close) next_state = dram_cmd_pkg::st_idle;
            dram_cmd_pkg::op_mrw:
            begin
              next_ret = dram_cmd_pkg::st_active;
              next_state = dram_cmd_pkg::st_mrw;
            end
            dram_cmd_pkg::op_mrr:
            begin
              next_ret = dram_cmd_pkg::st_active;
              next_state = dram_cmd_pkg::st_mrr;
            end
            dram_cmd_pkg::op_pde:
            begin
              next_ret = dram_cmd_pkg::st_active;
              next_state = dram_cmd_pkg::st_power_down;
            end
            default: bad = 1'b1;
          endcase
        end
      end
      dram_cmd_pkg::st_self_ref:
      begin
        if (take)
        begin
          case (op)
            dram_cmd_pkg::op_nop: ;
            dram_cmd_pkg::op_srx: next_state = dram_cmd_pkg::st_idle;
            dram_cmd_pkg::op_pde:
            begin
              next_ret = dram_cmd_pkg::st_self_ref;
              next_state = dram_cmd_pkg::st_power_down;
            end
            dram_cmd_pkg::op_mrw:
            begin
              next_ret = dram_cmd_pkg::st_self_ref;
              next_state = train_req ? dram_cmd_pkg::st_training : dram_cmd_pkg::st_mrw;
            end
            dram_cmd_pkg::op_mrr:
            begin
              next_ret = dram_cmd_pkg::st_self_ref;
              next_state = dram_cmd_pkg::st_mrr;
            end
            dram_cmd_pkg::op_mpc: if (train_req) next_state = dram_cmd_pkg::st_training;
            default: bad = 1'b1;
          endcase
        end
      end
      dram_cmd_pkg::st_power_down:
      begin
        if (take && op == dram_cmd_pkg::op_pdx)
          next_state = ret_state;
        else if (take && op != dram_cmd_pkg::op_nop)
          bad = 1'b1;
      end
      dram_cmd_pkg::st_training:
      begin
        // Training is left only by a mode write that clears the training bit.
        if (take && op == dram_cmd_pkg::op_mrw && !train_req)
          next_state = dram_cmd_pkg::st_idle;
        else if (take && op != dram_cmd_pkg::op_nop && op != dram_cmd_pkg::op_mrw &&
                 op != dram_cmd_pkg::op_mpc)
          bad = 1'b1;
      end
      dram_cmd_pkg::st_mrr: next_state = ret_state;
      dram_cmd_pkg::st_mrw: next_state = ret_state;
      dram_cmd_pkg::st_read: if (read_done) next_state = dram_cmd_pkg::st_active;
      dram_cmd_pkg::st_write: if (write_done) next_state = dram_cmd_pkg::st_active;
      default: next_state = dram_cmd_pkg::st_idle;
    endcase
  end

  // Reset state is idle with all banks closed; the controller initialises from here.
  always_ff @(posedge link_clk_in or posedge link_rst)
  begin
    if (link_rst)
    begin
      state <= dram_cmd_pkg::st_idle;
      ret_state <= dram_cmd_pkg::st_idle;
      link_ready_out <= 1'b0;
      cmd_error_out <= 1'b0;
    end
    else
    begin
      state <= next_state;
      ret_state <= next_ret;
      link_ready_out <= next_state != dram_cmd_pkg::st_read && next_state != dram_cmd_pkg::st_write &&
                        next_state != dram_cmd_pkg::st_mrr && next_state != dram_cmd_pkg::st_mrw;
      cmd_error_out <= cmd_in.valid && op != dram_cmd_pkg::op_nop && (!can_take || bad);
    end
  end

  genvar g;
  generate
    for (g = 0; g < dram_cmd_pkg::BANKS; g++)
    begin : bank_gen
      always_ff @(posedge link_clk_in or posedge link_rst)
      begin
        if (link_rst)
        begin
          bank_open[g] <= 1'b0;
          open_row[g] <= '0;
        end
        else if (act_go && cmd_in.bank == g)
        begin
          bank_open[g] <= 1'b1;
          open_row[g] <= cmd_in.row;
        end
        else if (pre_go && cmd_in.bank == g)
          bank_open[g] <= 1'b0;
      end
    end
  endgenerate

  always_comb
  begin
    merged = buffer;
    merged[beat_idx*BB +: BB] = wr_data_in;
  end

  always_ff @(posedge link_clk_in or posedge link_rst)
  begin
    if (link_rst)
    begin
      mode <= dram_cmd_pkg::MODE_RESET;
      ack_sync <= 2'b00;
      ack_seen <= 1'b0;
      req_tgl <= 1'b0;
      req <= '0;
      buffer <= '0;
      beat_cnt <= 3'h0;
      start_beat <= 3'h0;
      pending <= 1'b0;
      streaming <= 1'b0;
      rd_valid_out <= 1'b0;
      rd_data_out <= '0;
    end
    else
    begin
      ack_sync <= {ack_sync[0], ack_tgl};
      ack_seen <= ack_sync[1];
      rd_valid_out <= 1'b0;
      if (mrw_go)
        mode <= cmd_in.mode;
      if (mrr_go)
      begin
        rd_valid_out <= 1'b1;
        rd_data_out <= BB'(mode);
      end
      if (rd_go || wr_go)
      begin
        start_beat <= col_beat;
        beat_cnt <= 3'h0;
        req <= {wr_go, cmd_in.bank, open_row[cmd_in.bank], fetch_idx, buffer};
        if (rd_go)
        begin
          req_tgl <= ~req_tgl;
          pending <= 1'b1;
        end
      end
      if (state == dram_cmd_pkg::st_read)
      begin
        if (pending && ack_edge)
        begin
          buffer <= rsp;
          pending <= 1'b0;
          streaming <= 1'b1;
        end
        if (streaming)
        begin
          rd_valid_out <= 1'b1;
          rd_data_out <= buffer[beat_idx*BB +: BB];
          beat_cnt <= 3'(beat_cnt + 3'h1);
          if (read_done)
            streaming <= 1'b0;
        end
      end
      if (state == dram_cmd_pkg::st_write)
      begin
        if (!pending && wr_valid_in)
        begin
          buffer <= merged;
          beat_cnt <= 3'(beat_cnt + 3'h1);
          if (beat_cnt == dram_cmd_pkg::LAST_BEAT)
          begin
            req.data <= merged;
            req_tgl <= ~req_tgl;
            pending <= 1'b1;
          end
        end
        if (write_done)
          pending <= 1'b0;
      end
    end
  end

  // Core side: the fetch word is held stable in req while its toggle crosses.
  logic [dram_cmd_pkg::FETCH_BITS-1:0] mem [2**AW];
  logic [1:0] req_sync;
  logic req_seen;
  logic [dram_cmd_pkg::BANKS-1:0] open_sync;
  logic [1:0] lvl_sync0;
  logic sr_lvl;
  logic tr_lvl;
  wire req_edge = req_sync[1] ^ req_seen;
  wire [AW-1:0] mem_idx = {req.bank, req.row[ROW_KEEP-1:0], req.fetch};

  always_ff @(posedge link_clk_in or posedge link_rst)
  begin
    if (link_rst)
    begin
      sr_lvl <= 1'b0;
      tr_lvl <= 1'b0;
    end
    else
    begin
      sr_lvl <= next_state == dram_cmd_pkg::st_self_ref;
      tr_lvl <= next_state == dram_cmd_pkg::st_training;
    end
  end

  always_ff @(posedge core_clk_in)
  begin
    if (req_edge && req.write)
      mem[mem_idx] <= req.data;
  end

  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      req_sync <= 2'b00;
      req_seen <= 1'b0;
      ack_tgl <= 1'b0;
      rsp <= '0;
      access_count_out <= 16'h0000;
      open_sync <= '0;
      bank_open_out <= '0;
      lvl_sync0 <= 2'b00;
      self_refresh_out <= 1'b0;
      training_out <= 1'b0;
    end
    else
    begin
      req_sync <= {req_sync[0], req_tgl};
      req_seen <= req_sync[1];
      if (req_edge)
      begin
        if (!req.write)
          rsp <= mem[mem_idx];
        ack_tgl <= ~ack_tgl;
        access_count_out <= 16'(access_count_out + 16'h0001);
      end
      open_sync <= bank_open;
      bank_open_out <= open_sync;
      lvl_sync0 <= {sr_lvl, tr_lvl};
      self_refresh_out <= lvl_sync0[1];
      training_out <= lvl_sync0[0];
    end
  end

endmodule

// ### dram_bank_command_state_machine_chk.sv
`timescale 1ns/100ps
module dram_bank_command_state_machine_chk (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic link_clk_in,
  input wire logic reset_n_in,
  input wire dram_cmd_pkg::cmd_type cmd_in,
  input wire logic wr_valid_in,
  input wire logic [dram_cmd_pkg::BEAT_BITS-1:0] wr_data_in,
  input wire logic link_ready_out,
  input wire logic rd_valid_out,
  input wire logic [dram_cmd_pkg::BEAT_BITS-1:0] rd_data_out,
  input wire logic cmd_error_out,
  input wire logic [dram_cmd_pkg::BANKS-1:0] bank_open_out,
  input wire logic self_refresh_out,
  input wire logic training_out,
  input wire logic [15:0] access_count_out
);
  wire logic link_rst = reset_in || !reset_n_in;
  wire logic taken = cmd_in.valid && link_ready_out;
  wire logic is_mrr = cmd_in.valid && cmd_in.op == dram_cmd_pkg::op_mrr;
  wire logic is_mrw = cmd_in.valid && cmd_in.op == dram_cmd_pkg::op_mrw;

  a_refused_flag: assert property (@(posedge link_clk_in) disable iff (link_rst)
    (cmd_in.valid && cmd_in.op != dram_cmd_pkg::op_nop && !link_ready_out) |=> cmd_error_out)
    else $error("command while busy not flagged");
  a_closed_read: assert property (@(posedge link_clk_in) disable iff (link_rst)
    (taken && cmd_in.op == dram_cmd_pkg::op_rd && bank_open_out == '0) |=> cmd_error_out)
    else $error("read with all banks closed not flagged");
  a_mrr_return: assert property (@(posedge link_clk_in) disable iff (link_rst)
    (taken && is_mrr && !training_out) |=> rd_valid_out && !link_ready_out ##1 !rd_valid_out && link_ready_out)
    else $error("mode read did not return");
  a_mrw_return: assert property (@(posedge link_clk_in) disable iff (link_rst)
    (taken && is_mrw && !cmd_in.mode[0] && !training_out) |=> !link_ready_out ##1 link_ready_out)
    else $error("mode write did not return");
  a_burst_eight: assert property (@(posedge link_clk_in) disable iff (link_rst)
    ($rose(rd_valid_out) && !$past(taken && is_mrr)) |-> rd_valid_out [*8] ##1 !rd_valid_out)
    else $error("read burst is not eight beats");
  a_burst_busy: assert property (@(posedge link_clk_in) disable iff (link_rst)
    ($rose(rd_valid_out) && !$past(taken && is_mrr)) |-> !link_ready_out [*7] ##1 (link_ready_out && rd_valid_out))
    else $error("ready out of step with read data");
  a_reset_quiet: assert property (@(posedge link_clk_in) disable iff (reset_in)
    !reset_n_in |-> !link_ready_out && !rd_valid_out && !cmd_error_out)
    else $error("link outputs active in reset");
  a_reset_banks: assert property (@(posedge core_clk_in) disable iff (reset_in)
    !reset_n_in [*3] |-> bank_open_out == '0 && !training_out && !self_refresh_out)
    else $error("state flags survive reset");
  a_count_step: assert property (@(posedge core_clk_in) disable iff (link_rst)
    access_count_out != $past(access_count_out) |-> access_count_out == $past(access_count_out) + 16'h1)
    else $error("access count jumped");
endmodule

// ### dram_ctrl_model.sv
`timescale 1ns/100ps
module dram_ctrl_model (
  input wire logic link_clk_in,
  input wire logic link_ready_in,
  input wire logic rd_valid_in,
  input wire logic [31:0] rd_data_in,
  output dram_cmd_pkg::cmd_type cmd_out,
  output logic wr_valid_out,
  output logic [31:0] wr_data_out
);
  logic [31:0] beats [8];
  initial
  begin
    cmd_out = '0;
    wr_valid_out = 1'b0;
    wr_data_out = '0;
  end
  // Waiting for ready keeps commands back until reset and set-up are over.
  task automatic issue(input dram_cmd_pkg::cmd_type c, input logic wait_ready, output logic ok);
    int n;
    n = 0;
    do
    begin
      @(posedge link_clk_in);
      n++;
    end
    while (wait_ready && !link_ready_in && n < 400);
    ok = n < 400;
    cmd_out <= c;
    @(posedge link_clk_in);
    cmd_out <= ~c;
  endtask
  // Eight beats with a stall; the idle data line shows the inverse of the last beat.
  task automatic write_beats(input logic [31:0] base);
    for (int i = 0; i < 8; i++)
    begin
      if (i == 3)
      begin
        wr_valid_out <= 1'b0;
        wr_data_out <= ~(base + 32'h2);
        @(posedge link_clk_in);
      end
      wr_valid_out <= 1'b1;
      wr_data_out <= base + 32'(i);
      @(posedge link_clk_in);
    end
    wr_valid_out <= 1'b0;
    wr_data_out <= ~(base + 32'h7);
  endtask
  task automatic read_beats(input int cnt, output logic ok);
    int n;
    n = 0;
    do
    begin
      @(posedge link_clk_in);
      n++;
    end
    while (!rd_valid_in && n < 100);
    ok = n < 100;
    for (int i = 0; i < cnt; i++)
    begin
      beats[i] = rd_data_in;
      if (i < cnt - 1)
        @(posedge link_clk_in);
    end
  endtask
endmodule

// ### dram_bank_command_state_machine_tb.sv
`timescale 1ns/100ps
module dram_bank_command_state_machine_tb;
  logic core_clk_in = 1'b0;
  logic link_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic reset_n_in = 1'b0;
  dram_cmd_pkg::cmd_type cmd_in;
  logic wr_valid_in, link_ready_out, rd_valid_out, cmd_error_out, self_refresh_out, training_out, ok;
  logic [31:0] wr_data_in, rd_data_out;
  logic [7:0] bank_open_out;
  logic [15:0] access_count_out, c0;
  int err_count = 0;
  int cmp_count = 0;
  initial forever #4 core_clk_in = ~core_clk_in;
  initial
  begin
    #13;
    forever #40 link_clk_in = ~link_clk_in;
  end
  dram_bank_command_state_machine u_dut (.core_clk_in(core_clk_in), .reset_in(reset_in),
    .link_clk_in(link_clk_in), .reset_n_in(reset_n_in), .cmd_in(cmd_in), .wr_valid_in(wr_valid_in),
    .wr_data_in(wr_data_in), .link_ready_out(link_ready_out), .rd_valid_out(rd_valid_out),
    .rd_data_out(rd_data_out), .cmd_error_out(cmd_error_out), .bank_open_out(bank_open_out),
    .self_refresh_out(self_refresh_out), .training_out(training_out), .access_count_out(access_count_out));
  dram_ctrl_model u_ctrl (.link_clk_in(link_clk_in), .link_ready_in(link_ready_out), .rd_valid_in(rd_valid_out),
    .rd_data_in(rd_data_out), .cmd_out(cmd_in), .wr_valid_out(wr_valid_in), .wr_data_out(wr_data_in));
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    if (err_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic need(input logic k);
    if (k !== 1'b1)
    begin
      err_count++;
      $display("MISMATCH wait expected 1 seen 0");
      results();
    end
  endtask
  function automatic dram_cmd_pkg::cmd_type mk(dram_cmd_pkg::op_type op, logic [2:0] b, logic [7:0] c, logic [7:0] m);
    mk = '{1'b1, op, b, {11'h0, b}, c, m};
  endfunction
  task automatic link(input int n);
    repeat (n) @(posedge link_clk_in);
  endtask
  task automatic go(input dram_cmd_pkg::cmd_type c, input logic w);
    u_ctrl.issue(c, w, ok);
    need(ok);
  endtask
  task automatic expect_err(input dram_cmd_pkg::cmd_type c);
    go(c, 1'b1);
    @(negedge link_clk_in);
    check("cmd_error", cmd_error_out, 32'h1);
  endtask
  task automatic t_access();
    c0 = access_count_out;
    go(mk(dram_cmd_pkg::op_act, 3'h5, 8'h00, 8'h00), 1'b1);
    link(2);
    check("bank_open", bank_open_out, 32'h20);
    go(mk(dram_cmd_pkg::op_wr, 3'h5, 8'h00, 8'h00), 1'b1);
    fork
      u_ctrl.write_beats(32'ha5a50000);
      begin
        go(mk(dram_cmd_pkg::op_act, 3'h1, 8'h00, 8'h00), 1'b0);
        @(negedge link_clk_in);
        check("refused", cmd_error_out, 32'h1);
      end
    join
    go(mk(dram_cmd_pkg::op_rd, 3'h5, 8'h01, 8'h00), 1'b1);
    u_ctrl.read_beats(8, ok);
    need(ok);
    for (int i = 0; i < 8; i++)
      check("seq_beat", u_ctrl.beats[i], 32'ha5a50000 + 32'((i + 2) % 8));
    go(mk(dram_cmd_pkg::op_mrw, 3'h0, 8'h00, 8'h02), 1'b1);
    go(mk(dram_cmd_pkg::op_rd, 3'h5, 8'h03, 8'h00), 1'b1);
    u_ctrl.read_beats(8, ok);
    need(ok);
    for (int i = 0; i < 8; i++)
      check("ilv_beat", u_ctrl.beats[i], 32'ha5a50000 + 32'(6 ^ i));
    link(2);
    check("count", access_count_out, c0 + 16'h3);
  endtask
  task automatic t_errors();
    expect_err(mk(dram_cmd_pkg::op_rd, 3'h2, 8'h00, 8'h00));
    expect_err(mk(dram_cmd_pkg::op_act, 3'h5, 8'h00, 8'h00));
    go(mk(dram_cmd_pkg::op_pre, 3'h5, 8'h00, 8'h00), 1'b1);
    link(2);
    check("bank_open", bank_open_out, 32'h0);
    expect_err(mk(dram_cmd_pkg::op_rd, 3'h5, 8'h00, 8'h00));
  endtask
  task automatic t_modes();
    go(mk(dram_cmd_pkg::op_sre, 3'h0, 8'h00, 8'h00), 1'b1);
    go(mk(dram_cmd_pkg::op_mrr, 3'h0, 8'h00, 8'h00), 1'b1);
    u_ctrl.read_beats(1, ok);
    need(ok);
    check("mrr_sr", u_ctrl.beats[0][7:0], 32'h02);
    go(mk(dram_cmd_pkg::op_pde, 3'h0, 8'h00, 8'h00), 1'b1);
    go(mk(dram_cmd_pkg::op_pdx, 3'h0, 8'h00, 8'h00), 1'b1);
    link(2);
    check("self_ref", self_refresh_out, 32'h1);
    go(mk(dram_cmd_pkg::op_srx, 3'h0, 8'h00, 8'h00), 1'b1);
    go(mk(dram_cmd_pkg::op_pde, 3'h0, 8'h00, 8'h00), 1'b1);
    go(mk(dram_cmd_pkg::op_pdx, 3'h0, 8'h00, 8'h00), 1'b1);
    go(mk(dram_cmd_pkg::op_mrw, 3'h0, 8'h00, 8'h01), 1'b1);
    go(mk(dram_cmd_pkg::op_mpc, 3'h0, 8'h00, 8'h00), 1'b1);
    link(8);
    check("training", training_out, 32'h1);
    go(mk(dram_cmd_pkg::op_mrw, 3'h0, 8'h00, 8'h00), 1'b1);
    link(2);
    check("training", training_out, 32'h0);
    go(mk(dram_cmd_pkg::op_mpc, 3'h0, 8'h00, 8'h01), 1'b1);
    link(2);
    check("mpc_training", training_out, 32'h1);
    go(mk(dram_cmd_pkg::op_mrw, 3'h0, 8'h00, 8'h00), 1'b1);
  endtask
  task automatic t_reset();
    go(mk(dram_cmd_pkg::op_mrw, 3'h0, 8'h00, 8'h02), 1'b1);
    go(mk(dram_cmd_pkg::op_act, 3'h3, 8'h00, 8'h00), 1'b1);
    link(2);
    reset_n_in <= 1'b0;
    link(4);
    check("bank_open", bank_open_out, 32'h0);
    check("ready", link_ready_out, 32'h0);
    reset_n_in <= 1'b1;
    go(mk(dram_cmd_pkg::op_mrr, 3'h0, 8'h00, 8'h00), 1'b1);
    u_ctrl.read_beats(1, ok);
    need(ok);
    check("mode", u_ctrl.beats[0][7:0], 32'(dram_cmd_pkg::MODE_RESET));
  endtask
  initial
  begin
    repeat (16) @(posedge core_clk_in);
    reset_in <= 1'b0;
    reset_n_in <= 1'b1;
    t_access();
    t_errors();
    t_modes();
    t_reset();
    results();
  end
endmodule
bind dram_bank_command_state_machine dram_bank_command_state_machine_chk u_chk (.core_clk_in(core_clk_in),
  .reset_in(reset_in), .link_clk_in(link_clk_in), .reset_n_in(reset_n_in), .cmd_in(cmd_in),
  .wr_valid_in(wr_valid_in), .wr_data_in(wr_data_in), .link_ready_out(link_ready_out),
  .rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out), .cmd_error_out(cmd_error_out),
  .bank_open_out(bank_open_out), .self_refresh_out(self_refresh_out), .training_out(training_out),
  .access_count_out(access_count_out));
